// >>> hdl/cmh_pkg.sv
package cmh_pkg;

  // Object count and the legal object number range carried on event ports.
  localparam int          NUM_OBJ   = 32;
  localparam logic [5:0]  OBJ_FIRST = 6'h01;
  localparam logic [5:0]  OBJ_LAST  = 6'h20;

  // Frame payload geometry.
  localparam int          NUM_BYTES  = 8;
  localparam logic [3:0]  LEN_MAX    = 4'h8;
  localparam logic [3:0]  BYTE_LAST  = 4'h7;
  localparam logic [3:0]  BYTE_INC   = 4'h1;
  localparam logic [3:0]  BYTE_FIRST = 4'h0;

  // Register byte offsets on the AXI4-Lite slave.
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFF_IRQ_ID    = 12'h010;
  localparam logic [11:0] OFF_TXRQ_1    = 12'h100;
  localparam logic [11:0] OFF_TXRQ_2    = 12'h104;
  localparam logic [11:0] OFF_FRESH_1   = 12'h120;
  localparam logic [11:0] OFF_FRESH_2   = 12'h124;
  localparam logic [11:0] WORD_MASK     = 12'hffc;

  // Reset values and identifier codes.
  localparam logic [31:0] RST_VECTOR    = 32'h0000_0000;
  localparam logic [15:0] ID_NONE       = 16'h0000;
  localparam logic [15:0] ID_STATUS     = 16'h8000;
  localparam logic [15:0] RST_IRQ_ID    = 16'h0000;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Read channel state.
  typedef enum logic {
    CMH_RD_IDLE = 1'b0,
    CMH_RD_RESP = 1'b1
  } cmh_rd_state_t;

  // End of a received frame, reported by the protocol core.
  typedef struct packed {
    logic       valid;
    logic       remote;
    logic [5:0] obj;
    logic [3:0] len_code;
    logic       remote_reply_enable;
    logic       irq_en;
  } cmh_rx_end_t;

  // Successful transmission of an object.
  typedef struct packed {
    logic       valid;
    logic [5:0] obj;
    logic       irq_en;
  } cmh_tx_done_t;

  // Flag update requested by software through the object access interface.
  typedef struct packed {
    logic       valid;
    logic [5:0] obj;
    logic       txrq_wr;
    logic       txrq_val;
    logic       fresh_wr;
    logic       fresh_val;
    logic       irqp_wr;
    logic       irqp_val;
  } cmh_sw_cmd_t;

  // Write of a whole data field into object storage.
  typedef struct packed {
    logic        valid;
    logic [5:0]  obj;
    logic [3:0]  len;
    logic [63:0] data;
  } cmh_store_t;

endpackage

// >>> hdl/cmh_status.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Payload byte 0 is the first byte shifted in, byte 7 the last.
// - A stored data frame writes all eight byte slots; extras hold unspecified values.
// - All status registers are read-only and reflect handler state only.
// - The interrupt identifier is a sixteen-bit read-only value naming the source.
// - With several sources pending, the highest priority one is reported.
// - Pending sources stay pending until software clears them.
// - Interrupt request is high while identifier is nonzero and enable is set.
// - The status interrupt outranks every object interrupt.
// - Lower object numbers outrank higher ones.
// - Object interrupts clear only by clearing that object's pending flag.
// - Reading the status register clears the status interrupt.
// - Identifier codes: zero none, 1 to 32 object, 0x8000 status.
// - Transmit request vector: objects 1-16 in word one, 17-32 in word two.
// - Transmit request changes only by software, remote reception, or transmission done.
// - Fresh data vector uses the same ordering as the transmit request vector.
// - Fresh data updates on data reception, transmission done, or software.
// - Fresh data one means new data written since software last cleared it.
// - Length codes 9 to 15 count as eight data bytes.
// - Remote frame sets transmit request only when remote reply is enabled.
module cmh_status (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // AXI4-Lite slave.
  input  wire logic [11:0]          s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [11:0]          s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  // Protocol core and handler events.
  input  wire logic                 rx_byte_valid_i,
  input  wire logic [7:0]           rx_byte_i,
  input  wire cmh_pkg::cmh_rx_end_t rx_end_i,
  input  wire cmh_pkg::cmh_tx_done_t tx_done_i,
  input  wire cmh_pkg::cmh_sw_cmd_t sw_cmd_i,
  input  wire logic                 status_irq_set_i,
  input  wire logic                 status_read_i,
  input  wire logic                 module_irq_enable_i,
  // Results.
  output cmh_pkg::cmh_store_t       store_o,
  output logic [31:0]               object_irq_pending_o,
  output logic                      irq_o
);

  // Identifier selection: status first, then the lowest pending object number.
  function automatic logic [15:0] pick_id(input logic stat, input logic [31:0] pend);
    logic [15:0] r;
    r = cmh_pkg::ID_NONE;
    if (stat) begin
      r = cmh_pkg::ID_STATUS;
    end else begin
      for (int i = cmh_pkg::NUM_OBJ - 1; i >= 0; i--) begin
        if (pend[i]) begin
          r = 16'(i + 1);
        end
      end
    end
    return r;
  endfunction

  // Object number to one-hot bit; numbers outside 1..32 select nothing.
  function automatic logic [31:0] obj_onehot(input logic [5:0] obj);
    logic [31:0] r;
    r = cmh_pkg::RST_VECTOR;
    if (obj >= cmh_pkg::OBJ_FIRST && obj <= cmh_pkg::OBJ_LAST) begin
      r = 32'h0000_0001 << (obj - cmh_pkg::OBJ_FIRST);
    end
    return r;
  endfunction

  // Register address check, shared by the read and write channels.
  function automatic logic is_mapped(input logic [11:0] addr);
    logic [11:0] a;
    a = addr & cmh_pkg::WORD_MASK;
    return (a == cmh_pkg::OFF_IRQ_ID) || (a == cmh_pkg::OFF_TXRQ_1) ||
           (a == cmh_pkg::OFF_TXRQ_2) || (a == cmh_pkg::OFF_FRESH_1) ||
           (a == cmh_pkg::OFF_FRESH_2);
  endfunction

  // Handler state.
  logic [31:0]              txrq;
  logic [31:0]              fresh;
  logic [31:0]              irqp;
  logic                     stat_pend;
  logic [15:0]              irq_id;
  logic [63:0]              rx_buf;
  logic [3:0]               rx_cnt;
  cmh_pkg::cmh_store_t      store;
  logic                     irq;

  logic [31:0]              next_txrq;
  logic [31:0]              next_fresh;
  logic [31:0]              next_irqp;
  logic                     next_stat_pend;
  logic [15:0]              next_irq_id;
  logic [63:0]              next_rx_buf;
  logic [3:0]               next_rx_cnt;
  cmh_pkg::cmh_store_t      next_store;

  // Event decoding into per-object set and clear masks.
  wire  [31:0] rx_oh  = obj_onehot(rx_end_i.obj) & {32{rx_end_i.valid}};
  wire  [31:0] tx_oh  = obj_onehot(tx_done_i.obj) & {32{tx_done_i.valid}};
  wire  [31:0] sw_oh  = obj_onehot(sw_cmd_i.obj) & {32{sw_cmd_i.valid}};
  wire         rx_rmt = rx_end_i.remote;

  wire  [31:0] set_txrq  = (rx_oh & {32{rx_rmt & rx_end_i.remote_reply_enable}}) |
                           (sw_oh & {32{sw_cmd_i.txrq_wr & sw_cmd_i.txrq_val}});
  wire  [31:0] clr_txrq  = tx_oh | (sw_oh & {32{sw_cmd_i.txrq_wr & ~sw_cmd_i.txrq_val}});
  wire  [31:0] set_fresh = (rx_oh & {32{~rx_rmt}}) |
                           (sw_oh & {32{sw_cmd_i.fresh_wr & sw_cmd_i.fresh_val}});
  wire  [31:0] clr_fresh = tx_oh | (sw_oh & {32{sw_cmd_i.fresh_wr & ~sw_cmd_i.fresh_val}});
  wire  [31:0] set_irqp  = (rx_oh & {32{~rx_rmt & rx_end_i.irq_en}}) |
                           (tx_oh & {32{tx_done_i.irq_en}}) |
                           (sw_oh & {32{sw_cmd_i.irqp_wr & sw_cmd_i.irqp_val}});
  wire  [31:0] clr_irqp  = sw_oh & {32{sw_cmd_i.irqp_wr & ~sw_cmd_i.irqp_val}};

  // Per-object flag update; a set in the same cycle as a clear wins so no event is lost.
  genvar g;
  generate
    for (g = 0; g < cmh_pkg::NUM_OBJ; g++) begin : g_obj
      assign next_fresh[g] = set_fresh[g] | (fresh[g] & ~clr_fresh[g]);
      assign next_txrq[g]  = set_txrq[g] | (txrq[g] & ~clr_txrq[g]);
      assign next_irqp[g]  = set_irqp[g] | (irqp[g] & ~clr_irqp[g]);
    end
  endgenerate

  assign next_stat_pend = status_irq_set_i | (stat_pend & ~status_read_i);

  assign next_irq_id = pick_id(next_stat_pend, next_irqp);

  // Payload assembly: each arriving byte lands in the next slot in shift order.
  // Bytes past the eighth are dropped; slots not reached keep stale contents.
  always_comb begin
    next_rx_buf = rx_buf;
    next_rx_cnt = rx_cnt;
    if (rx_end_i.valid) begin
      next_rx_cnt = cmh_pkg::BYTE_FIRST;
    end else if (rx_byte_valid_i && rx_cnt <= cmh_pkg::BYTE_LAST) begin
      next_rx_buf[rx_cnt[2:0] * 8 +: 8] = rx_byte_i;
      next_rx_cnt = rx_cnt + cmh_pkg::BYTE_INC;
    end
  end

  // Store request for a received data frame; the whole field is always written.
  always_comb begin
    next_store       = '0;
    next_store.obj   = rx_end_i.obj;
    next_store.data  = rx_buf;
    next_store.len   = (rx_end_i.len_code > cmh_pkg::LEN_MAX) ? cmh_pkg::LEN_MAX :
                       rx_end_i.len_code;
    next_store.valid = rx_end_i.valid & ~rx_rmt & (rx_oh != cmh_pkg::RST_VECTOR);
  end

  // Handler flops.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      txrq      <= cmh_pkg::RST_VECTOR;
      fresh     <= cmh_pkg::RST_VECTOR;
      irqp      <= cmh_pkg::RST_VECTOR;
      stat_pend <= 1'b0;
      irq_id    <= cmh_pkg::RST_IRQ_ID;
      rx_buf    <= '0;
      rx_cnt    <= cmh_pkg::BYTE_FIRST;
      store     <= '0;
      irq       <= 1'b0;
    end else begin
      txrq      <= next_txrq;
      fresh     <= next_fresh;
      irqp      <= next_irqp;
      stat_pend <= next_stat_pend;
      irq_id    <= next_irq_id;
      rx_buf    <= next_rx_buf;
      rx_cnt    <= next_rx_cnt;
      store     <= next_store;
      irq       <= (next_irq_id != cmh_pkg::ID_NONE) & module_irq_enable_i;
    end
  end

  assign store_o              = store;
  assign object_irq_pending_o = irqp;
  assign irq_o                = irq;

  // ---------------- AXI4-Lite slave ----------------
  cmh_pkg::cmh_rd_state_t   rd_state;
  cmh_pkg::cmh_rd_state_t   next_rd_state;
  logic [31:0]              rdata;
  logic [31:0]              next_rdata;
  logic [1:0]               rresp;
  logic [1:0]               next_rresp;
  logic [31:0]              rd_word;
  logic                     aw_held;
  logic                     w_held;
  logic [11:0]              awaddr;
  logic                     bvalid;
  logic [1:0]               bresp;
  logic                     awready;
  logic                     wready;
  logic                     next_aw_held;
  logic                     next_w_held;
  logic [11:0]              next_awaddr;
  logic                     next_bvalid;
  logic [1:0]               next_bresp;

  wire  [11:0] rd_addr = s_axi_araddr_i & cmh_pkg::WORD_MASK;
  wire         ar_fire = s_axi_arvalid_i & (rd_state == cmh_pkg::CMH_RD_IDLE);
  wire         aw_fire = s_axi_awvalid_i & awready;
  wire         w_fire  = s_axi_wvalid_i & wready;

  // Read word selection; every mapped word is a live view of handler state, unmapped ones read zero.
  // read-only status
  always_comb begin
    if (rd_addr == cmh_pkg::OFF_IRQ_ID) begin
      rd_word = {16'h0000, irq_id};
    end else if (rd_addr == cmh_pkg::OFF_TXRQ_1) begin
      rd_word = {16'h0000, txrq[15:0]};
    end else if (rd_addr == cmh_pkg::OFF_TXRQ_2) begin
      rd_word = {16'h0000, txrq[31:16]};
    end else if (rd_addr == cmh_pkg::OFF_FRESH_1) begin
      rd_word = {16'h0000, fresh[15:0]};
    end else if (rd_addr == cmh_pkg::OFF_FRESH_2) begin
      rd_word = {16'h0000, fresh[31:16]};
    end else begin
      rd_word = cmh_pkg::RDATA_ZERO;
    end
  end

  // Read channel: one read at a time, data one cycle after the address is taken.
  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    case (rd_state)
      cmh_pkg::CMH_RD_IDLE: begin
        if (ar_fire) begin
          next_rd_state = cmh_pkg::CMH_RD_RESP;
          next_rdata    = rd_word;
          next_rresp    = is_mapped(s_axi_araddr_i) ? cmh_pkg::RESP_OKAY :
                          cmh_pkg::RESP_SLVERR;
        end
      end
      cmh_pkg::CMH_RD_RESP: begin
        if (s_axi_rready_i) begin
          next_rd_state = cmh_pkg::CMH_RD_IDLE;
          next_rdata    = cmh_pkg::RDATA_ZERO;
        end
      end
      default: begin
        next_rd_state = cmh_pkg::CMH_RD_IDLE;
      end
    endcase
  end

  // Write channel: address and data taken in either order, then one response.
  // writes ignored
  always_comb begin
    next_aw_held = aw_held | aw_fire;
    next_w_held  = w_held | w_fire;
    next_awaddr  = aw_fire ? s_axi_awaddr_i : awaddr;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (next_aw_held && next_w_held && !bvalid) begin
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(next_awaddr) ? cmh_pkg::RESP_OKAY : cmh_pkg::RESP_SLVERR;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
  end

  // Bus flops; awready and wready are registered, while arready and rvalid are decoded from rd_state.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_state <= cmh_pkg::CMH_RD_IDLE;
      rdata    <= cmh_pkg::RDATA_ZERO;
      rresp    <= cmh_pkg::RESP_OKAY;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      awaddr   <= '0;
      bvalid   <= 1'b0;
      bresp    <= cmh_pkg::RESP_OKAY;
      awready  <= 1'b0;
      wready   <= 1'b0;
    end else begin
      rd_state <= next_rd_state;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      awaddr   <= next_awaddr;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      awready  <= ~next_aw_held & ~next_bvalid;
      wready   <= ~next_w_held & ~next_bvalid;
    end
  end

  // Write data and strobes carry nothing this block stores.
  assign s_axi_awready_o = awready;
  assign s_axi_wready_o  = wready;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign s_axi_arready_o = (rd_state == cmh_pkg::CMH_RD_IDLE);
  assign s_axi_rvalid_o  = (rd_state == cmh_pkg::CMH_RD_RESP);
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;

endmodule // cmh_status

// >>> verification/cmh_status_chk.sv
`timescale 1ns/1ps

// Port-level checks of the status block; everything runs on one clock.
module cmh_status_chk (
  input wire logic                  clock_i,
  input wire logic                  rst_i,
  input wire logic                  s_axi_arvalid_i,
  input wire logic                  s_axi_arready_o,
  input wire logic                  s_axi_rvalid_o,
  input wire logic                  s_axi_rready_i,
  input wire logic [1:0]            s_axi_rresp_o,
  input wire cmh_pkg::cmh_rx_end_t  rx_end_i,
  input wire cmh_pkg::cmh_tx_done_t tx_done_i,
  input wire cmh_pkg::cmh_sw_cmd_t  sw_cmd_i,
  input wire logic                  status_irq_set_i,
  input wire logic                  module_irq_enable_i,
  input wire cmh_pkg::cmh_store_t   store_o,
  input wire logic [31:0]           object_irq_pending_o,
  input wire logic                  irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // The read address handshake opens every read.
  sequence s_ar_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  // A data frame ends on a legal object, which must be stored.
  sequence s_data_end;
    rx_end_i.valid && !rx_end_i.remote && rx_end_i.obj != 6'h00 &&
      rx_end_i.obj <= cmh_pkg::OBJ_LAST;
  endsequence

  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read answer missing");
  a_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rresp_o)) else $error("read answer dropped");
  a_store_frame: assert property (s_data_end |=>
    store_o.valid && store_o.obj == $past(rx_end_i.obj)) else $error("frame not stored");
  a_store_len: assert property (s_data_end |=> store_o.len ==
    (($past(rx_end_i.len_code) > cmh_pkg::LEN_MAX) ? cmh_pkg::LEN_MAX :
    $past(rx_end_i.len_code))) else $error("stored length wrong");
  a_remote_nostore: assert property (rx_end_i.valid && rx_end_i.remote |=>
    !store_o.valid) else $error("remote frame stored");
  a_pend_sticky: assert property (!sw_cmd_i.valid |=>
    ($past(object_irq_pending_o) & ~object_irq_pending_o) == 32'h0000_0000)
    else $error("pending flag dropped");
  a_txdone_pend: assert property (tx_done_i.valid && tx_done_i.irq_en &&
    tx_done_i.obj != 6'h00 && tx_done_i.obj <= cmh_pkg::OBJ_LAST |=>
    object_irq_pending_o[$past(tx_done_i.obj) - 6'h01]) else $error("tx pending missing");
  a_irq_gate: assert property (!module_irq_enable_i |=> !irq_o)
    else $error("irq while disabled");
  a_status_irq: assert property (status_irq_set_i && module_irq_enable_i |=> irq_o)
    else $error("status irq missing");
endmodule // cmh_status_chk

bind cmh_status cmh_status_chk u_chk (.clock_i, .rst_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rresp_o, .rx_end_i, .tx_done_i, .sw_cmd_i,
  .status_irq_set_i, .module_irq_enable_i, .store_o, .object_irq_pending_o, .irq_o);

// >>> verification/cmh_node_model.sv
`timescale 1ns/1ps

// Far-side node: shifts frames in and reports finished transmissions.
module cmh_node_model (
  input  wire logic             clock_i,
  output logic                  rx_byte_valid_o,
  output logic [7:0]            rx_byte_o,
  output cmh_pkg::cmh_rx_end_t  rx_end_o,
  output cmh_pkg::cmh_tx_done_t tx_done_o
);
  initial begin
    rx_byte_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_end_o = '0;
    tx_done_o = '0;
  end

  // Sends one frame; remote frames carry no payload.
  task automatic frame(input logic [5:0] o, input logic [3:0] lc, input logic rm,
                       input logic rre, input logic ie, input logic [63:0] d);
    int n;
    n = rm ? 0 : ((lc > 4'h8) ? 8 : int'(lc));
    for (int k = 0; k < n; k++) begin
      @(posedge clock_i);
      rx_byte_valid_o <= 1'b1;
      rx_byte_o <= d[8*k +: 8];
    end
    @(posedge clock_i);
    rx_byte_valid_o <= 1'b0;
    rx_byte_o <= ~rx_byte_o; // The idle byte line must not look valid.
    rx_end_o <= '{1'b1, rm, o, lc, rre, ie};
    @(posedge clock_i);
    rx_end_o <= '0;
  endtask

  // Reports a successful transmission of one object.
  task automatic sent(input logic [5:0] o, input logic ie);
    @(posedge clock_i);
    tx_done_o <= '{1'b1, o, ie};
    @(posedge clock_i);
    tx_done_o <= '0;
  endtask
endmodule // cmh_node_model

// >>> verification/tb_cmh_status.sv
`timescale 1ns/1ps

module tb_cmh_status;
  localparam logic [1:0] OK = cmh_pkg::RESP_OKAY;
  logic                  clock_i = 1'b0;
  logic                  rst_i   = 1'b1;
  logic [11:0]           awaddr  = 12'h000;
  logic [11:0]           araddr  = 12'h000;
  logic [31:0]           wdata   = 32'h0000_0000;
  logic                  awvalid = 1'b0;
  logic                  wvalid  = 1'b0;
  logic                  bready  = 1'b0;
  logic                  arvalid = 1'b0;
  logic                  rready  = 1'b0;
  logic                  st_set  = 1'b0;
  logic                  st_read = 1'b0;
  logic                  irq_en  = 1'b0;
  cmh_pkg::cmh_sw_cmd_t  sw_cmd  = '0;
  logic [15:0]           seed    = 16'h6bc5;
  logic                  awready, wready, bvalid, arready, rvalid, rxv, irq;
  logic [1:0]            bresp, rresp;
  logic [31:0]           rdata, pend;
  logic [7:0]            rxb;
  cmh_pkg::cmh_rx_end_t  rx_end;
  cmh_pkg::cmh_tx_done_t tx_done;
  cmh_pkg::cmh_store_t   store, es;
  cmh_pkg::cmh_store_t   sq[$];
  logic [33:0]           er;
  logic [33:0]           rq[$];
  int                    fails = 0, num_checks = 0, cyc = 0;
  logic [11:0]           adr [6] = '{cmh_pkg::OFF_IRQ_ID, cmh_pkg::OFF_TXRQ_1,
    cmh_pkg::OFF_TXRQ_2, cmh_pkg::OFF_FRESH_1, cmh_pkg::OFF_FRESH_2, 12'h200};

  initial forever #25 clock_i = ~clock_i;

  cmh_status uut (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .rx_byte_valid_i(rxv), .rx_byte_i(rxb), .rx_end_i(rx_end),
    .tx_done_i(tx_done), .sw_cmd_i(sw_cmd), .status_irq_set_i(st_set),
    .status_read_i(st_read), .module_irq_enable_i(irq_en), .store_o(store),
    .object_irq_pending_o(pend), .irq_o(irq));
  cmh_node_model node (.clock_i(clock_i), .rx_byte_valid_o(rxv), .rx_byte_o(rxb),
    .rx_end_o(rx_end), .tx_done_o(tx_done));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Bytes past the length are unspecified, so they are masked off.
  function automatic logic [63:0] msk(input logic [3:0] n);
    return (n >= 4'h8) ? '1 : ((64'h1 << (8 * n)) - 64'h1);
  endfunction

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (e !== g) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    chk("stores_left", 64'h0, sq.size());
    chk("reads_left", 64'h0, rq.size());
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Read one register; the monitor compares the answer.
  // A random stall before rready makes the slave hold its answer for a cycle.
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock_i);
    rq.push_back({r, d});
    seed = lfsr(seed);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    if (seed[0]) @(posedge clock_i);
    rready <= 1'b1;
    do @(posedge clock_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Write random data; address and data are released as each is taken.
  task automatic wr(input logic [11:0] a, input logic [1:0] r);
    @(posedge clock_i);
    seed = lfsr(seed);
    awaddr <= a;
    wdata <= {seed, ~seed};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", r, bresp);
  endtask

  task automatic ev(input cmh_pkg::cmh_sw_cmd_t c, input logic s, input logic q);
    @(posedge clock_i);
    sw_cmd <= c;
    st_set <= s;
    st_read <= q;
    @(posedge clock_i);
    sw_cmd <= '0;
    st_set <= 1'b0;
    st_read <= 1'b0;
  endtask

  // Data frame with random payload; the expected store is queued first.
  task automatic frm(input logic [5:0] o, input logic [3:0] lc, input logic ie);
    logic [63:0] d;
    repeat (4) begin
      seed = lfsr(seed);
      d = {d[47:0], seed};
    end
    sq.push_back('{1'b1, o, (lc > 4'h8) ? 4'h8 : lc, d});
    node.frame(o, lc, 1'b0, 1'b0, ie, d);
  endtask

  // Monitor: each result takes the oldest expectation of its kind.
  always @(posedge clock_i) begin
    if (store.valid === 1'b1) begin
      chk("store_due", 64'h1, sq.size() > 0);
      es = (sq.size() > 0) ? sq.pop_front() : '0;
      chk("store_obj", es.obj, store.obj);
      chk("store_len", es.len, store.len);
      chk("store_data", es.data & msk(es.len), store.data & msk(es.len));
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk("read_due", 64'h1, rq.size() > 0);
      er = (rq.size() > 0) ? rq.pop_front() : '1;
      chk("rdata", er, {rresp, rdata});
    end
  end

  // A hang counts as a mismatch; the run needs about three hundred cycles.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      results();
    end
  end

  initial begin
    logic [1:0] r;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      r = (k == 5) ? cmh_pkg::RESP_SLVERR : OK;
      rd(adr[k], 32'h0000_0000, r);
      wr(adr[k], r);
      rd(adr[k], 32'h0000_0000, r);
    end
    irq_en <= 1'b1;
    for (int k = 0; k < 16; k++) frm(6'(k + 1), 4'(k), 1'b1);
    frm(6'h14, 4'h8, 1'b0);
    rd(cmh_pkg::OFF_FRESH_1, 32'h0000_ffff, OK);
    rd(cmh_pkg::OFF_FRESH_2, 32'h0000_0008, OK);
    rd(cmh_pkg::OFF_IRQ_ID, 32'h0000_0001, OK);
    chk("irq", 1'b1, irq);
    ev('{1'b1, 6'h01, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0}, 1'b0, 1'b0);
    ev('0, 1'b1, 1'b0);
    rd(cmh_pkg::OFF_IRQ_ID, 32'h0000_8000, OK);
    ev('0, 1'b0, 1'b1);
    rd(cmh_pkg::OFF_IRQ_ID, 32'h0000_0002, OK);
    irq_en <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk("irq", 1'b0, irq);
    node.frame(6'h03, 4'h0, 1'b1, 1'b1, 1'b0, 64'h0);
    node.frame(6'h04, 4'h0, 1'b1, 1'b0, 1'b0, 64'h0);
    node.frame(6'h11, 4'h0, 1'b1, 1'b1, 1'b0, 64'h0);
    rd(cmh_pkg::OFF_TXRQ_1, 32'h0000_0004, OK);
    rd(cmh_pkg::OFF_TXRQ_2, 32'h0000_0001, OK);
    node.sent(6'h03, 1'b0);
    node.sent(6'h11, 1'b1);
    rd(cmh_pkg::OFF_TXRQ_1, 32'h0000_0000, OK);
    rd(cmh_pkg::OFF_TXRQ_2, 32'h0000_0000, OK);
    rd(cmh_pkg::OFF_FRESH_1, 32'h0000_fffb, OK);
    chk("pending", 32'h0001_fffe, pend);
    ev('{1'b1, 6'h20, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0}, 1'b0, 1'b0);
    ev('{1'b1, 6'h14, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0}, 1'b0, 1'b0);
    rd(cmh_pkg::OFF_TXRQ_2, 32'h0000_8000, OK);
    rd(cmh_pkg::OFF_FRESH_2, 32'h0000_8000, OK);
    ev('{1'b1, 6'h20, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1}, 1'b0, 1'b0);
    rd(cmh_pkg::OFF_TXRQ_2, 32'h0000_0000, OK);
    chk("pending", 32'h8001_fffe, pend);
    // Let the monitor take the last answer before the queues are audited.
    repeat (2) @(posedge clock_i);
    results();
  end
endmodule // tb_cmh_status
